// *** core/rpp_pkg.sv ***
package rpp_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS = 1_000_000;
   localparam int PROG_CYCLE_MS = 5;
   localparam int PREFAULT_MS = 20;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int PROG_CYCLES = (PROG_CYCLE_MS * MS_NS) / CLK_PERIOD_NS;
   localparam int AVG_TAPS = PREFAULT_MS / PROG_CYCLE_MS;
   // ----------------------------------------------------------------
   // Sizes and settings
   // ----------------------------------------------------------------
   localparam int NUM_GROUPS = 8;
   localparam int LOG_DEPTH = 12;
   localparam logic [23:0] THR_RESET = 24'h00_2710; // 100 kW in 0.01 kW steps.
   localparam logic [23:0] THR_MAX = 24'h98_9680; // 100 000 kW.
   localparam logic [18:0] DLY_RESET = 19'h0_0014; // In 5 ms steps.
   localparam logic [18:0] DLY_MAX = 19'h5_7E40; // 1800 s in 5 ms steps.
   localparam logic [6:0] RELEASE_PCT = 7'h61; // 97 percent.
   localparam logic [16:0] RATIO_MAX = 17'h1_E848; // 1250.00.
   localparam logic [2:0] LN_ON = 3'h1;
   localparam logic [2:0] LN_BLOCKED = 3'h2;
   localparam logic [2:0] LN_TEST = 3'h3;
   localparam logic [2:0] LN_TEST_BLOCKED = 3'h4;
   localparam logic [2:0] LN_OFF = 3'h5;
   localparam logic [1:0] COND_NORMAL = 2'h0;
   localparam logic [1:0] COND_START = 2'h1;
   localparam logic [1:0] COND_TRIP = 2'h2;
   localparam logic [1:0] COND_BLOCKED = 2'h3;
   // ----------------------------------------------------------------
   // Register map (byte offsets) and fields
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_GROUP = 12'h000;
   localparam logic [11:0] ADDR_MODE = 12'h004;
   localparam logic [11:0] ADDR_CMD = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   localparam logic [11:0] ADDR_EXPECT = 12'h014;
   localparam logic [11:0] ADDR_REMAIN = 12'h018;
   localparam logic [11:0] ADDR_RATIO = 12'h01C;
   localparam logic [11:0] ADDR_COUNT = 12'h020;
   localparam logic [11:0] ADDR_PREFAULT = 12'h024;
   localparam logic [11:0] ADDR_TIME = 12'h028;
   localparam logic [11:0] ADDR_LOG_IDX = 12'h030;
   localparam logic [11:0] ADDR_LOG_TS = 12'h034;
   localparam logic [11:0] ADDR_LOG_INFO = 12'h038;
   localparam logic [11:0] ADDR_LOG_PWR = 12'h03C;
   localparam logic [11:0] ADDR_SET_BASE = 12'h040;
   localparam logic [11:0] ADDR_SET_END = 12'h07C;
   localparam int MODE_LN_LSB = 0;
   localparam int MODE_FORCE_LSB = 4;
   localparam int MODE_FORCE_EN = 6;
   localparam int MODE_SIDE = 7;
   localparam int MODE_EVT_ON = 8;
   localparam int MODE_EVT_OFF = 9;
   localparam int CMD_CNT_CLR = 0;
   localparam int SET_INSTANT = 31;
   // Event port: one lane per output, all lanes share one time stamp.
   typedef struct packed {
      logic [2:0] valid; // Lanes: 0 start, 1 trip, 2 blocked.
      logic [2:0] on;    // One for an ON event, zero for OFF.
      logic [31:0] ts;   // Milliseconds.
   } rpp_evt_t;
   typedef struct packed {
      logic [31:0] ts;
      logic [2:0] mask;
      logic [2:0] grp;
      logic [31:0] pwr;
   } rpp_log_t;
endpackage : rpp_pkg

// *** core/rpp_stage.sv ***
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
// Operation
// - Eight setting groups, one chosen by a common group selector.
// - Instant or time-delayed operation chosen per configuration.
// - Delayed operation uses a fixed configured delay, no curve.
// - Start, trip, blocked each push time-stamped ON/OFF events.
// - Instant mode issues start and trip events with one stamp.
// - Event time stamps count whole milliseconds.
// - Cumulative count of start, trip, blocked ON events, clearable.
// - Store the 20 ms averaged power before the trigger as pre-fault data.
// - Side select picks which current measurement feeds the power value.
// - Node mode 1 on, 2 blocked, 3 test, 4 test-blocked, 5 off.
// - Forcing enabled lets a force code override the status.
// - Mode and force settings stay outside the setting groups.
// - Threshold in 0.01 kW steps to 100000 kW; ratio computed always.
// - Release only below 97 percent of the threshold.
// - Start only while no blocking condition is active.
// - Read-only condition code 0 normal, 1 start, 2 trip, 3 blocked.
// - Read-only expected operating time in 5 ms steps.
// - Read-only signed remaining time in 5 ms steps while timing.
// - Read-only measured-to-setting ratio in hundredths.
// - Blocking sampled each program cycle; while picked up raises blocked, drops start.
// - ON events logged with process data in a ring of twelve.
module rpp_stage
   import rpp_pkg::*;
#(
   parameter int MS_TICKS = rpp_pkg::MS_CYCLES,
   parameter int PROG_TICKS = rpp_pkg::PROG_CYCLES
)
(
   input wire logic CLK_SYS_I,                // System clock, 40 MHz.
   input wire logic RST_I,                    // Synchronous reset, active high.
   input wire logic PSEL_I,                   // APB select.
   input wire logic PENABLE_I,                // APB access phase.
   input wire logic PWRITE_I,                 // APB direction.
   input wire logic [11:0] PADDR_I,           // APB byte address.
   input wire logic [31:0] PWDATA_I,          // APB write data.
   output logic [31:0] PRDATA_O,              // APB read data.
   output logic PREADY_O,                     // APB ready.
   output logic PSLVERR_O,                    // APB error on unmapped address.
   input wire logic PWR_VALID_I,              // New power sample strobe.
   input wire logic signed [31:0] PWR_A_I,    // Power from first CT side.
   input wire logic signed [31:0] PWR_B_I,    // Power from second CT side.
   input wire logic BLOCK_I,                  // Blocking matrix input, async.
   output logic START_O,                      // Start output.
   output logic TRIP_O,                       // Trip output.
   output logic BLOCKED_O,                    // Blocked output.
   output rpp_pkg::rpp_evt_t EVT_O            // Event push to buffer.
);
   import rpp_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [23:0] thr_mem [NUM_GROUPS];
   logic [18:0] dly_mem [NUM_GROUPS];
   logic inst_mem [NUM_GROUPS];
   rpp_log_t log_mem [LOG_DEPTH];
   logic [2:0] group_reg;
   logic [9:0] mode_reg;
   logic [3:0] log_idx_reg;
   logic [3:0] log_ptr_reg;
   logic [31:0] ms_div_reg;
   logic [31:0] pc_div_reg;
   logic [31:0] time_reg;
   logic blk_meta_reg;
   logic blk_sync_reg;
   logic blk_reg;
   logic [31:0] mag_reg;
   logic [31:0] avg_reg [AVG_TAPS];
   logic pickup_reg;
   logic [18:0] cnt_reg;
   logic [2:0] out_reg;
   logic [2:0] out_next;
   logic [2:0] raw_reg;
   logic [2:0] raw_next;
   logic [16:0] ratio_reg;
   logic [31:0] prefault_reg;
   logic [31:0] count_reg;
   logic [31:0] rdata;
   logic rd_err;
   logic wr_en;
   logic prog_tick;
   logic [23:0] thr;
   logic [18:0] dly;
   logic inst;
   logic [2:0] logical_node_operating_mode;
   logic [2:0] on_evt;
   logic [2:0] off_evt;
   logic [31:0] avg_sum;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Reverse power is the negative part of the signed power value.
   function automatic logic [31:0] rev_mag_f(input logic signed [31:0] p);
      rev_mag_f = (p < 0) ? 32'(-p) : 32'h0000_0000;
   endfunction : rev_mag_f

   // Ratio in hundredths, clamped; a zero threshold reads as the maximum.
   function automatic logic [16:0] ratio_f(input logic [31:0] m, input logic [23:0] t);
      logic [39:0] q;
      q = 40'h00_0000_0000;
      if (t == 24'h00_0000)
      begin
         ratio_f = RATIO_MAX;
      end
      else
      begin
         q = (40'(m) * 40'd100) / 40'(t);
         ratio_f = (q > 40'(RATIO_MAX)) ? RATIO_MAX : q[16:0];
      end
   endfunction : ratio_f

   // Count of ones in an event lane mask.
   function automatic logic [1:0] ones_f(input logic [2:0] v);
      ones_f = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
   endfunction : ones_f

   // ----------------------------------------------------------------
   // Active setting group
   // ----------------------------------------------------------------
   // group selects set.
   assign thr = thr_mem[group_reg];
   assign dly = dly_mem[group_reg];
   assign inst = inst_mem[group_reg];
   assign logical_node_operating_mode = mode_reg[MODE_LN_LSB +: 3];

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Zero wait states: every access finishes in its first access cycle.
   assign PREADY_O = 1'b1;
   assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & ~rd_err;
   assign PSLVERR_O = PSEL_I & PENABLE_I & rd_err;

   // Static settings live apart from the group arrays.
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         group_reg <= 3'h0;
         mode_reg <= {2'h3, 1'b0, 1'b0, 2'h0, 1'b0, LN_ON};
         log_idx_reg <= 4'h0;
      end
      else if (wr_en)
      begin
         if (PADDR_I == ADDR_GROUP)
         begin
            group_reg <= PWDATA_I[2:0];
         end
         else if (PADDR_I == ADDR_MODE)
         begin
            mode_reg <= PWDATA_I[9:0];
         end
         else if (PADDR_I == ADDR_LOG_IDX)
         begin
            log_idx_reg <= (PWDATA_I[3:0] < 4'(LOG_DEPTH)) ? PWDATA_I[3:0] : 4'h0;
         end
      end
   end

   // Group settings; a threshold above the range is clamped.
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         for (int g = 0; g < NUM_GROUPS; g++)
         begin
            thr_mem[g] <= THR_RESET;
            dly_mem[g] <= DLY_RESET;
            inst_mem[g] <= 1'b0;
         end
      end
      else if (wr_en && PADDR_I >= ADDR_SET_BASE && PADDR_I <= ADDR_SET_END)
      begin
         if (PADDR_I[2] == 1'b0)
         begin
            thr_mem[PADDR_I[5:3]] <= (PWDATA_I[23:0] > THR_MAX) ? THR_MAX : PWDATA_I[23:0];
         end
         else
         begin
            dly_mem[PADDR_I[5:3]] <= (PWDATA_I[18:0] > DLY_MAX) ? DLY_MAX : PWDATA_I[18:0];
            inst_mem[PADDR_I[5:3]] <= PWDATA_I[SET_INSTANT];
         end
      end
   end

   // Read decode; misaligned or unknown addresses raise an error.
   always_comb
   begin
      rdata = 32'h0000_0000;
      rd_err = 1'b0;
      if (PADDR_I == ADDR_GROUP)
         rdata = {29'h0000_0000, group_reg};
      else if (PADDR_I == ADDR_MODE)
         rdata = {22'h00_0000, mode_reg};
      else if (PADDR_I == ADDR_CMD)
         rdata = 32'h0000_0000;
      else if (PADDR_I == ADDR_STATUS)
         rdata = {20'h0_0000, log_ptr_reg, 3'h0, pickup_reg, out_reg[2] ? COND_BLOCKED :
                  out_reg[1] ? COND_TRIP : out_reg[0] ? COND_START : COND_NORMAL, 2'h0};
      else if (PADDR_I == ADDR_EXPECT)
         rdata = inst ? 32'h0000_0000 : {13'h0000, dly};
      else if (PADDR_I == ADDR_REMAIN)
         rdata = (raw_reg == 3'b001 && !inst)
                 ? 32'(signed'({1'b0, dly}) - signed'({1'b0, cnt_reg})) : 32'h0000_0000;
      else if (PADDR_I == ADDR_RATIO)
         rdata = {15'h0000, ratio_reg};
      else if (PADDR_I == ADDR_COUNT)
         rdata = count_reg;
      else if (PADDR_I == ADDR_PREFAULT)
         rdata = prefault_reg;
      else if (PADDR_I == ADDR_TIME)
         rdata = time_reg;
      else if (PADDR_I == ADDR_LOG_IDX)
         rdata = {28'h000_0000, log_idx_reg};
      else if (PADDR_I == ADDR_LOG_TS)
         rdata = log_mem[log_idx_reg].ts;
      else if (PADDR_I == ADDR_LOG_INFO)
         rdata = {25'h000_0000, log_mem[log_idx_reg].grp, 1'b0, log_mem[log_idx_reg].mask};
      else if (PADDR_I == ADDR_LOG_PWR)
         rdata = log_mem[log_idx_reg].pwr;
      else if (PADDR_I >= ADDR_SET_BASE && PADDR_I <= ADDR_SET_END && PADDR_I[1:0] == 2'h0)
         rdata = PADDR_I[2] ? {inst_mem[PADDR_I[5:3]], 12'h000, dly_mem[PADDR_I[5:3]]}
                 : {8'h00, thr_mem[PADDR_I[5:3]]};
      else
         rd_err = 1'b1;
   end

   // Read data is registered at the setup edge and held until the next read.
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         PRDATA_O <= 32'h0000_0000;
      else if (PSEL_I && !PENABLE_I && !PWRITE_I)
         PRDATA_O <= rdata;
   end

   // ----------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------
   // millisecond stamp counter.
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I || ms_div_reg == 32'(MS_TICKS - 1))
         ms_div_reg <= 32'h0000_0000;
      else
         ms_div_reg <= ms_div_reg + 32'h0000_0001;
      if (RST_I)
         time_reg <= 32'h0000_0000;
      else if (ms_div_reg == 32'(MS_TICKS - 1))
         time_reg <= time_reg + 32'h0000_0001;
   end

   // Program cycle divider; the protection logic steps once per cycle.
   assign prog_tick = (pc_div_reg == 32'(PROG_TICKS - 1));
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I || prog_tick)
         pc_div_reg <= 32'h0000_0000;
      else
         pc_div_reg <= pc_div_reg + 32'h0000_0001;
   end

   // ----------------------------------------------------------------
   // Blocking input
   // ----------------------------------------------------------------
   // The pin is asynchronous, so it passes two flops before use.
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         blk_meta_reg <= 1'b0;
         blk_sync_reg <= 1'b0;
         blk_reg <= 1'b0;
      end
      else
      begin
         blk_meta_reg <= BLOCK_I;
         blk_sync_reg <= blk_meta_reg;
         if (prog_tick)
            blk_reg <= blk_sync_reg;
      end
   end

   // ----------------------------------------------------------------
   // Measurement, pick-up and ratio
   // ----------------------------------------------------------------
   // sample taken on strobe.
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         mag_reg <= 32'h0000_0000;
         for (int i = 0; i < AVG_TAPS; i++)
            avg_reg[i] <= 32'h0000_0000;
      end
      else if (PWR_VALID_I)
      begin
         mag_reg <= rev_mag_f(mode_reg[MODE_SIDE] ? PWR_B_I : PWR_A_I);
         avg_reg[0] <= mag_reg;
         for (int i = 1; i < AVG_TAPS; i++)
            avg_reg[i] <= avg_reg[i - 1];
      end
   end

   // Average of the samples preceding the present one.
   always_comb
   begin
      avg_sum = 32'h0000_0000;
      for (int i = 0; i < AVG_TAPS; i++)
         avg_sum = avg_sum + avg_reg[i];
      avg_sum = avg_sum / 32'(AVG_TAPS);
   end

   // Comparator with fixed hysteresis below the threshold.
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         pickup_reg <= 1'b0;
         ratio_reg <= 17'h0_0000;
      end
      else
      begin
         ratio_reg <= ratio_f(mag_reg, thr);
         if (mag_reg >= 32'(thr))
            pickup_reg <= 1'b1;
         else if (40'(mag_reg) * 40'd100 < 40'(thr) * 40'(RELEASE_PCT))
            pickup_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Stage logic
   // ----------------------------------------------------------------
   // Raw outputs step only on program ticks; lanes 0 start, 1 trip, 2 blocked.
   always_comb
   begin
      raw_next = raw_reg;
      if (prog_tick)
      begin
         if (logical_node_operating_mode == LN_OFF || !pickup_reg)
            raw_next = 3'b000;
         else if (blk_reg || logical_node_operating_mode == LN_BLOCKED || logical_node_operating_mode == LN_TEST_BLOCKED)
            raw_next = 3'b100;
         else if (inst)
            raw_next = 3'b011;
         else if (raw_reg[1] || (raw_reg[0] && cnt_reg + 19'h0_0001 >= dly))
            raw_next = 3'b011;
         else
            raw_next = 3'b001;
      end
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         raw_reg <= 3'b000;
         cnt_reg <= 19'h0_0000;
      end
      else
      begin
         raw_reg <= raw_next;
         // The start cycle itself is not counted, so trip comes a full delay later.
         if (prog_tick)
            cnt_reg <= (raw_next[0] && !raw_next[1] && raw_reg[0]) ? cnt_reg + 19'h0_0001
                       : 19'h0_0000;
      end
   end

   always_comb
   begin
      out_next = raw_next;
      if (mode_reg[MODE_FORCE_EN])
      begin
         case (mode_reg[MODE_FORCE_LSB +: 2])
            COND_START: out_next = 3'b001;
            COND_TRIP: out_next = 3'b011;
            COND_BLOCKED: out_next = 3'b100;
            default: out_next = raw_next;
         endcase
      end
   end

   assign on_evt = out_next & ~out_reg;
   assign off_evt = out_reg & ~out_next;

   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         out_reg <= 3'b000;
         EVT_O <= '0;
      end
      else
      begin
         out_reg <= out_next;
         EVT_O.valid <= (on_evt & {3{mode_reg[MODE_EVT_ON]}}) |
                        (off_evt & {3{mode_reg[MODE_EVT_OFF]}});
         EVT_O.on <= on_evt;
         EVT_O.ts <= time_reg;
      end
   end

   assign START_O = out_reg[0];
   assign TRIP_O = out_reg[1];
   assign BLOCKED_O = out_reg[2];

   // ----------------------------------------------------------------
   // Counter, pre-fault value and log
   // ----------------------------------------------------------------
   // count clear then add.
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         count_reg <= 32'h0000_0000;
      else if (wr_en && PADDR_I == ADDR_CMD && PWDATA_I[CMD_CNT_CLR])
         count_reg <= 32'(ones_f(on_evt));
      else
         count_reg <= count_reg + 32'(ones_f(on_evt));
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         log_ptr_reg <= 4'h0;
         prefault_reg <= 32'h0000_0000;
         for (int i = 0; i < LOG_DEPTH; i++)
            log_mem[i] <= '0;
      end
      else if (on_evt != 3'b000)
      begin
         prefault_reg <= avg_sum;
         log_mem[log_ptr_reg] <= '{ts: time_reg, mask: on_evt, grp: group_reg, pwr: mag_reg};
         log_ptr_reg <= (log_ptr_reg == 4'(LOG_DEPTH - 1)) ? 4'h0 : log_ptr_reg + 4'h1;
      end
   end
endmodule : rpp_stage

// *** test/rpp_stage_sva.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker for the protection stage.
// ------------------------------------------------------------
module rpp_stage_chk
   import rpp_pkg::*;
(
   input wire logic CLK_SYS_I,          // Clock.
   input wire logic RST_I,              // Reset.
   input wire logic PSEL_I,             // Select.
   input wire logic PENABLE_I,          // Access phase.
   input wire logic PREADY_O,           // Ready.
   input wire logic PSLVERR_O,          // Error.
   input wire logic START_O,            // Start.
   input wire logic TRIP_O,             // Trip.
   input wire logic BLOCKED_O,          // Blocked.
   input wire rpp_pkg::rpp_evt_t EVT_O  // Events.
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   // Zero wait states, so a master never stalls.
   property p_rdy; PSEL_I && PENABLE_I |-> PREADY_O; endproperty
   a_rdy: assert property (p_rdy) else $error("ready low in access");
   property p_err; !(PSEL_I && PENABLE_I) |-> !PSLVERR_O; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   property p_st_on; $rose(START_O) |-> EVT_O.valid[0] && EVT_O.on[0]; endproperty
   a_st_on: assert property (p_st_on) else $error("start rise without event");
   property p_st_off; $fell(START_O) |-> EVT_O.valid[0] && !EVT_O.on[0]; endproperty
   a_st_off: assert property (p_st_off) else $error("start fall without event");
   property p_tr_on; $rose(TRIP_O) |-> EVT_O.valid[1] && EVT_O.on[1]; endproperty
   a_tr_on: assert property (p_tr_on) else $error("trip rise without event");
   property p_bl_on; $rose(BLOCKED_O) |-> EVT_O.valid[2] && EVT_O.on[2]; endproperty
   a_bl_on: assert property (p_bl_on) else $error("block rise without event");
   property p_pulse; EVT_O.valid[2] |=> !EVT_O.valid[2]; endproperty
   a_pulse: assert property (p_pulse) else $error("event strobe too long");
   property p_excl; !(START_O && BLOCKED_O); endproperty
   a_excl: assert property (p_excl) else $error("start while blocked");
   property p_rst; $fell(RST_I) |-> !(START_O || TRIP_O || BLOCKED_O); endproperty
   a_rst: assert property (p_rst) else $error("outputs set after reset");
   c_start: cover property ($rose(START_O));
   c_block: cover property ($rose(BLOCKED_O));
   c_err: cover property (PSLVERR_O);
endmodule : rpp_stage_chk

// *** test/rpp_meas.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Measurement chain and blocking source.
// ------------------------------------------------------------
module rpp_meas #(
   parameter int PROG_TICKS = 200
)
(
   input wire logic clk_i,                // Clock.
   input wire logic rst_i,                // Reset.
   input wire logic signed [31:0] lvl_i,  // Power to deliver.
   input wire logic blk_i,                // Block request.
   output logic valid_o,                  // Sample strobe.
   output logic signed [31:0] pwr_a_o,    // First side power.
   output logic signed [31:0] pwr_b_o,    // Second side power.
   output logic block_o                   // Blocking level.
);
   int cnt = 0;
   // Phase follows reset so samples line up with the stage's cycle.
   always_ff @(posedge clk_i)
   begin
      cnt <= (rst_i || cnt == PROG_TICKS - 1) ? 0 : cnt + 1;
   end
   assign valid_o = (cnt == PROG_TICKS - 1);
   // Between strobes the bus carries junk, so stale data is never trusted.
   assign pwr_a_o = valid_o ? lvl_i : ~lvl_i;
   assign pwr_b_o = valid_o ? -lvl_i : lvl_i;
   assign block_o = blk_i;
endmodule : rpp_meas

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   import rpp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwrite = 1'b0, blk = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic signed [31:0] lvl = 32'sh0000_0000, pa, pb;
   logic vld, blkd, rdy, err, perr, start, trip, blocked;
   logic [2:0] outs;
   rpp_evt_t evt;
   int num_errors = 0, n_checks = 0, cyc;
   assign outs = {blocked, trip, start};
   rpp_stage #(.MS_TICKS(40), .PROG_TICKS(200)) DUT (.CLK_SYS_I(clk), .RST_I(rst),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(rdy), .PSLVERR_O(err), .PWR_VALID_I(vld), .PWR_A_I(pa),
      .PWR_B_I(pb), .BLOCK_I(blkd), .START_O(start), .TRIP_O(trip), .BLOCKED_O(blocked),
      .EVT_O(evt));
   rpp_meas #(.PROG_TICKS(200)) u_meas (.clk_i(clk), .rst_i(rst), .lvl_i(lvl), .blk_i(blk),
      .valid_o(vld), .pwr_a_o(pa), .pwr_b_o(pb), .block_o(blkd));
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk
   // One APB transfer; ends one idle cycle after the access edge.
   task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      q = prdata;
      perr = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : xf
   task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      xf(1'b0, a, 32'h0000_0000);
      chk(nm, e, q);
   endtask : rd
   task wfor(input int w, input logic v);
      for (cyc = 0; cyc < 3000 && outs[w] !== v; cyc++) @(posedge clk);
      chk("output level", v, outs[w]);
   endtask : wfor
   task results;
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   // Watchdog: the sequence needs well under ten thousand cycles.
   initial
   begin
      repeat (40000) @(posedge clk);
      num_errors++;
      results();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_MODE, 32'h0000_0301, "mode");
      rd(ADDR_SET_BASE, {8'h00, THR_RESET}, "threshold");
      rd(ADDR_SET_BASE + 12'h004, {13'h0000, DLY_RESET}, "delay");
      rd(ADDR_EXPECT, 32'h0000_0014, "expected time");
      rd(12'h0FC, 32'h0000_0000, "unmapped");
      chk("slverr", 1'b1, perr);
      xf(1'b1, 12'h058, 32'h0000_1388);
      xf(1'b1, 12'h05C, 32'h0000_0003);
      xf(1'b1, ADDR_GROUP, 32'h0000_0003);
      rd(ADDR_EXPECT, 32'h0000_0003, "group time");
      rd(ADDR_MODE, 32'h0000_0301, "mode kept");
      lvl <= -32'sh0000_1770;
      wfor(0, 1'b1);
      rd(ADDR_REMAIN, 32'h0000_0003, "remaining");
      wfor(1, 1'b1);
      chk("delay span", 32'h0000_0255, cyc);
      rd(ADDR_REMAIN, 32'h0000_0000, "remain tripped");
      rd(ADDR_RATIO, 32'h0000_0078, "ratio");
      rd(ADDR_COUNT, 32'h0000_0002, "count");
      lvl <= -32'sh0000_1324;
      repeat (600) @(posedge clk);
      chk("hold", 1'b1, start);
      lvl <= -32'sh0000_12C0;
      wfor(0, 1'b0);
      xf(1'b1, ADDR_CMD, 32'h0000_0001);
      rd(ADDR_COUNT, 32'h0000_0000, "cleared");
      xf(1'b1, 12'h05C, 32'h8000_0003);
      rd(ADDR_EXPECT, 32'h0000_0000, "instant time");
      lvl <= -32'sh0000_1770;
      for (cyc = 0; cyc < 3000 && evt.valid[0] !== 1'b1; cyc++) @(posedge clk);
      chk("pair", 32'h0000_000F, {evt.valid[1:0], evt.on[1:0]});
      chk("stamp", 32'h0000_003B, evt.ts);
      rd(ADDR_PREFAULT, 32'h0000_12F2, "pre-fault");
      xf(1'b1, ADDR_LOG_IDX, 32'h0000_0002);
      rd(ADDR_LOG_INFO, 32'h0000_0033, "log info");
      rd(ADDR_LOG_TS, 32'h0000_003B, "log stamp");
      lvl <= 32'sh0000_0000;
      wfor(1, 1'b0);
      blk <= 1'b1;
      repeat (400) @(posedge clk);
      lvl <= -32'sh0000_1770;
      wfor(2, 1'b1);
      chk("no start", 1'b0, start);
      xf(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk("blocked code", COND_BLOCKED, q[3:2]);
      xf(1'b1, ADDR_MODE, 32'h0000_0305);
      wfor(2, 1'b0);
      blk <= 1'b0;
      lvl <= 32'sh0000_0000;
      xf(1'b1, ADDR_MODE, 32'h0000_0361);
      wfor(1, 1'b1);
      xf(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk("forced code", COND_TRIP, q[3:2]);
      xf(1'b1, ADDR_MODE, 32'h0000_0301);
      wfor(1, 1'b0);
      xf(1'b1, ADDR_MODE, 32'h0000_0381);
      lvl <= 32'sh0000_1770;
      wfor(0, 1'b1);
      results();
   end
endmodule : tb_top
bind rpp_stage rpp_stage_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .START_O(START_O),
   .TRIP_O(TRIP_O), .BLOCKED_O(BLOCKED_O), .EVT_O(EVT_O));
